// [rtl/agc_defs.svh]
// Contract
// - Fast peak mode: high recovery constant is (high interval + 1) times mid constant.
// - Analog upper level spans lower level to 63; counted exceedances raise high flag.
// - In any gain control mode an analog high over-range lowers gain by attack step.
// - Analog lower level spans 0 to upper level; peak mode raises gain without low overload.
// - Power mode with blocking bit set: analog low overload stops any gain rise.
// - Analog high over-range declared when upper peak count is reached, 0 to 255.
// - Analog low overload declared when lower peak count is reached, 0 to 255.
// - Peak mode analog under-range raises gain by analog recovery step, 0 to 31.
// - Analog attack step spans 0 to 31 gain indices, default 2.
// - Half-band overload detector works only while its enable is 1, default 1.
// - Half-band window is 0 to 7 half-band output cycles, default 1.
// - One half-band overload when samples above a level in window exceed sample count.
// - Half-band flag only when overloads in a period exceed upper or lower event count.
// - Half-band upper level 0 to 16383, default 13044, compared with every sample.
// - Mid recovery constant is (mid interval + 1) times low interval, fast peak mode only.
// - Half-band high over-range lowers gain by half-band attack step, 0 to 31.
`ifndef AGC_DEFS_SVH
`define AGC_DEFS_SVH
`define AGC_CTRL_OFS 8'h00
`define AGC_APD_OFS 8'h04
`define AGC_STEP_OFS 8'h08
`define AGC_HB_OFS 8'h0C
`define AGC_HBLVL_OFS 8'h10
`define AGC_REC_OFS 8'h14
`define AGC_URLVL_OFS 8'h18
`define AGC_STATUS_OFS 8'h1C
`define AGC_IRQ_STAT_OFS 8'h20
`define AGC_IRQ_MASK_OFS 8'h24
`define AGC_TC_MID_OFS 8'h28
`define AGC_TC_HIGH_OFS 8'h2C
`define CTRL_PEAK 0
`define CTRL_POWER 1
`define CTRL_FAST 2
`define CTRL_BLOCK 3
`define CTRL_HB_ON 4
`define APD_UP_F 5:0
`define APD_LO_F 13:8
`define APD_UPCNT_F 23:16
`define APD_LOCNT_F 31:24
`define STEP_ATK_F 4:0
`define STEP_REC_F 12:8
`define STEP_HBATK_F 20:16
`define STEP_PWR_F 28:24
`define HB_WIN_F 2:0
`define HB_SCNT_F 7:4
`define HB_UPEV_F 15:8
`define HB_LOEV_F 23:16
`define HBLVL_UP_F 13:0
`define HBLVL_LO_F 29:16
`define REC_HIGH_F 5:0
`define REC_MID_F 13:8
`define REC_LOW_F 31:16
`define URLVL_F 13:0
`define PERIOD_F 31:16
`define CTRL_RST 32'h0000_0011
`define APD_RST 32'h0306_0C15
`define STEP_RST 32'h0002_0002
`define HB_RST 32'h0003_0611
`define HBLVL_RST 32'h2710_32F4
`define REC_RST 32'h0032_0204
`define URLVL_RST 32'h0100_1CA7
`endif

// [rtl/agc_pkg.sv]
package agc_pkg;
  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;
  typedef logic [7:0] peak_cnt_t;
  typedef logic [3:0] irq_vec_t;
endpackage

// [rtl/agc_cnt_if.sv]
`timescale 1ns/1ns
interface agc_cnt_if;
  import agc_pkg::*;
  logic clr;
  logic evt;
  logic strict;
  peak_cnt_t limit;
  logic flag;
  modport cnt (input clr, input evt, input strict, input limit, output flag);
  modport user (output clr, output evt, output strict, output limit, input flag);
endinterface

// [rtl/agc_event_counter.sv]
`timescale 1ns/1ns
module agc_event_counter import agc_pkg::*; (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Counting port.
  agc_cnt_if.cnt bus
);
  peak_cnt_t cnt_q;

  // An event in the clearing cycle opens the new period, so it is never lost.
  // period clear
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 8'h00;
    end else if (bus.clr) begin
      cnt_q <= bus.evt ? 8'h01 : 8'h00;
    end else if (bus.evt && cnt_q != 8'hFF) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Analog counts fire on reaching the limit, half-band counts on exceeding it.
  // reach or exceed
  assign bus.flag = bus.strict ? (cnt_q > bus.limit) : (cnt_q >= bus.limit);

  AST_CNT_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    bus.clr |=> cnt_q == {7'h00, $past(bus.evt)})
    else $error("counter did not restart at period start");
endmodule

// [rtl/agc_hb_window.sv]
`timescale 1ns/1ns
module agc_hb_window #(
  parameter int SW = 14
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Settings.
  input wire logic on_i,
  input wire logic [2:0] win_i,
  input wire logic [3:0] thr_i,
  input wire logic [SW-1:0] upper_i,
  input wire logic [SW-1:0] lower_i,
  // Samples at the half-band output rate.
  input wire logic valid_i,
  input wire logic [SW-1:0] sample_i,
  // One overload per window.
  output logic hi_evt_o,
  output logic lo_evt_o
);
  logic [2:0] pos_q;
  logic [3:0] hi_n_q;
  logic [3:0] lo_n_q;
  logic [2:0] win_len;
  logic [3:0] hi_n;
  logic [3:0] lo_n;
  logic win_end;

  // A zero window setting is taken as a window of one cycle.
  always_comb begin
    win_len = (win_i == 3'h0) ? 3'h1 : win_i;
    hi_n = hi_n_q + {3'h0, (sample_i > upper_i) && hi_n_q != 4'hF};
    lo_n = lo_n_q + {3'h0, (sample_i > lower_i) && lo_n_q != 4'hF};
    win_end = (pos_q + 3'h1 >= win_len) || (pos_q == 3'h7);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pos_q <= 3'h0;
      hi_n_q <= 4'h0;
      lo_n_q <= 4'h0;
      hi_evt_o <= 1'b0;
      lo_evt_o <= 1'b0;
    end else begin
      hi_evt_o <= 1'b0;
      lo_evt_o <= 1'b0;
      if (!on_i) begin
        pos_q <= 3'h0;
        hi_n_q <= 4'h0;
        lo_n_q <= 4'h0;
      end else if (valid_i) begin
        if (win_end) begin
          hi_evt_o <= hi_n > thr_i;
          lo_evt_o <= lo_n > thr_i;
          pos_q <= 3'h0;
          hi_n_q <= 4'h0;
          lo_n_q <= 4'h0;
        end else begin
          pos_q <= pos_q + 3'h1;
          hi_n_q <= hi_n;
          lo_n_q <= lo_n;
        end
      end
    end
  end

  AST_HB_OFF: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !on_i |=> !hi_evt_o && !lo_evt_o)
    else $error("half-band overload while detector disabled");
  AST_HB_EVT_CAUSE: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    hi_evt_o |-> $past(valid_i) && $past(on_i) && $past(win_end))
    else $error("half-band overload without closing sample");
endmodule

// [rtl/agc_peak_overload_detect.sv]
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "agc_defs.svh"
module agc_peak_overload_detect import agc_pkg::*; #(
  parameter int AW = 8,
  parameter int GW = 8,
  parameter logic [GW-1:0] GAIN_MAX = {GW{1'b1}},
  parameter logic [GW-1:0] GAIN_INIT = {GW{1'b1}}
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // AXI4-Lite write channels.
  input wire logic [AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels.
  input wire logic [AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Detector inputs.
  input wire logic apd_valid_i,
  input wire logic [5:0] apd_level_i,
  input wire logic hb_valid_i,
  input wire logic [13:0] hb_sample_i,
  input wire logic pwr_rise_req_i,
  // Gain control and interrupt.
  output logic [GW-1:0] gain_index_o,
  output logic gain_update_o,
  output logic irq_o
);
  generate
    if (AW < 6 || AW > 8 || GW < 6) begin : g_bad
      $error("AW must be 6 to 8 and GW at least 6");
    end
  endgenerate

  logic [31:0] ctrl_q, apd_q, step_q, hb_q, hblvl_q, rec_q, urlvl_q;
  irq_vec_t irq_stat_q, irq_mask_q, irq_set, irq_clr;
  logic [3:0] flags_q, w_strb_q;
  logic aw_have_q, w_have_q, wr_go;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rd_mux;
  logic [15:0] per_q;
  logic upd, ur_seen_q, rise_ok, hb_hi_evt, hb_lo_evt;
  logic [22:0] tc_mid_q;
  logic [29:0] tc_high_q, rec_tmr_q;
  logic [GW-1:0] gain_q, gain_d;
  logic [5:0] up_eff, rise;
  logic apd_hi, apd_lo, hb_hi, hb_lo, over, agc_on;
  logic [6:0] atk;
  logic [GW:0] sum;

  // Register offsets are word aligned and sit below the transfer map's end.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `AGC_TC_HIGH_OFS);
  endfunction

  // Byte lanes not strobed keep their old contents.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // Write address and data may arrive in either order; the response waits for both.
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid_o;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= 8'(s_axi_awaddr_i);
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Settings registers; read-only offsets accept and ignore writes.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= `CTRL_RST;
      apd_q <= `APD_RST;
      step_q <= `STEP_RST;
      hb_q <= `HB_RST;
      hblvl_q <= `HBLVL_RST;
      rec_q <= `REC_RST;
      urlvl_q <= `URLVL_RST;
      irq_mask_q <= 4'h0;
    end else if (wr_go) begin
      case (aw_addr_q)
        `AGC_CTRL_OFS: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000_001F;
        `AGC_APD_OFS: apd_q <= merge(apd_q, w_data_q, w_strb_q) & 32'hFFFF_3F3F;
        `AGC_STEP_OFS: step_q <= merge(step_q, w_data_q, w_strb_q) & 32'h1F1F_1F1F;
        `AGC_HB_OFS: hb_q <= merge(hb_q, w_data_q, w_strb_q) & 32'h00FF_FFF7;
        `AGC_HBLVL_OFS: hblvl_q <= merge(hblvl_q, w_data_q, w_strb_q) & 32'h3FFF_3FFF;
        `AGC_REC_OFS: rec_q <= merge(rec_q, w_data_q, w_strb_q) & 32'hFFFF_3F3F;
        `AGC_URLVL_OFS: urlvl_q <= merge(urlvl_q, w_data_q, w_strb_q) & 32'hFFFF_3FFF;
        `AGC_IRQ_MASK_OFS: irq_mask_q <= w_strb_q[0] ? w_data_q[3:0] : irq_mask_q;
        default: ;
      endcase
    end
  end

  // Read data is sampled at address acceptance and held until taken.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (8'(s_axi_araddr_i))
      `AGC_CTRL_OFS: rd_mux = ctrl_q;
      `AGC_APD_OFS: rd_mux = apd_q;
      `AGC_STEP_OFS: rd_mux = step_q;
      `AGC_HB_OFS: rd_mux = hb_q;
      `AGC_HBLVL_OFS: rd_mux = hblvl_q;
      `AGC_REC_OFS: rd_mux = rec_q;
      `AGC_URLVL_OFS: rd_mux = urlvl_q;
      `AGC_STATUS_OFS: rd_mux = {20'h00000, flags_q, 8'(gain_q)};
      `AGC_IRQ_STAT_OFS: rd_mux = {28'h0000000, irq_stat_q};
      `AGC_IRQ_MASK_OFS: rd_mux = {28'h0000000, irq_mask_q};
      `AGC_TC_MID_OFS: rd_mux = {9'h000, tc_mid_q};
      `AGC_TC_HIGH_OFS: rd_mux = {2'b00, tc_high_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // One read at a time; the address channel stalls while data waits.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_mux;
      s_axi_rresp_o <= mapped(8'(s_axi_araddr_i)) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // Gain update period; a setting of 0 or 1 updates on every cycle.
  assign upd = (per_q + 16'h0001 >= urlvl_q[`PERIOD_F]);
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      per_q <= 16'h0000;
    end else begin
      per_q <= upd ? 16'h0000 : per_q + 16'h0001;
    end
  end

  // An upper level written below the lower level is lifted to it.
  // upper level range
  assign up_eff = (apd_q[`APD_UP_F] < apd_q[`APD_LO_F]) ? apd_q[`APD_LO_F] : apd_q[`APD_UP_F];

  agc_cnt_if cif[4] ();
  assign cif[0].evt = apd_valid_i && (apd_level_i > up_eff);
  assign cif[0].limit = apd_q[`APD_UPCNT_F];
  assign cif[0].strict = 1'b0;
  assign cif[1].evt = apd_valid_i && (apd_level_i > apd_q[`APD_LO_F]);
  assign cif[1].limit = apd_q[`APD_LOCNT_F];
  assign cif[1].strict = 1'b0;
  assign cif[2].evt = hb_hi_evt;
  assign cif[2].limit = hb_q[`HB_UPEV_F];
  assign cif[2].strict = 1'b1;
  assign cif[3].evt = hb_lo_evt;
  assign cif[3].limit = hb_q[`HB_LOEV_F];
  assign cif[3].strict = 1'b1;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_cnt
      assign cif[g].clr = upd;
      agc_event_counter u_cnt (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .bus(cif[g])
      );
    end
  endgenerate

  agc_hb_window #(.SW(14)) u_hb (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .on_i(ctrl_q[`CTRL_HB_ON]),
    .win_i(hb_q[`HB_WIN_F]),
    .thr_i(hb_q[`HB_SCNT_F]),
    .upper_i(hblvl_q[`HBLVL_UP_F]),
    .lower_i(hblvl_q[`HBLVL_LO_F]),
    .valid_i(hb_valid_i),
    .sample_i(hb_sample_i),
    .hi_evt_o(hb_hi_evt),
    .lo_evt_o(hb_lo_evt)
  );

  // A half-band peak above the under-range level marks the period as loud.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ur_seen_q <= 1'b0;
    end else begin
      ur_seen_q <= (upd ? 1'b0 : ur_seen_q) ||
                   (hb_valid_i && hb_sample_i > urlvl_q[`URLVL_F]);
    end
  end

  // Recovery time constants, kept registered to keep the multipliers off the update path.
  // mid and high constants
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tc_mid_q <= 23'h000000;
      tc_high_q <= 30'h00000000;
    end else begin
      tc_mid_q <= ({1'b0, rec_q[`REC_MID_F]} + 7'h01) * rec_q[`REC_LOW_F];
      tc_high_q <= ({1'b0, rec_q[`REC_HIGH_F]} + 7'h01) * tc_mid_q;
    end
  end

  // Gain decision at the period end from the counts of the closing period.
  always_comb begin
    apd_hi = cif[0].flag;
    apd_lo = cif[1].flag;
    hb_hi = cif[2].flag && ctrl_q[`CTRL_HB_ON];
    hb_lo = cif[3].flag && ctrl_q[`CTRL_HB_ON];
    agc_on = ctrl_q[`CTRL_PEAK] || ctrl_q[`CTRL_POWER];
    over = apd_hi || hb_hi;
    atk = {2'b00, apd_hi ? step_q[`STEP_ATK_F] : 5'h00} +
          {2'b00, hb_hi ? step_q[`STEP_HBATK_F] : 5'h00};
    rise_ok = ctrl_q[`CTRL_PEAK] && !apd_lo &&
              (!ctrl_q[`CTRL_FAST] || (rec_tmr_q >= tc_high_q && !ur_seen_q));
    rise = {1'b0, rise_ok ? step_q[`STEP_REC_F] : 5'h00};
    if (ctrl_q[`CTRL_POWER] && pwr_rise_req_i && !(ctrl_q[`CTRL_BLOCK] && apd_lo)) begin
      rise = rise + {1'b0, step_q[`STEP_PWR_F]};
    end
    sum = {1'b0, gain_q} + (GW+1)'(rise);
    gain_d = gain_q;
    if (agc_on && over) begin
      gain_d = ({1'b0, gain_q} > (GW+1)'(atk)) ? gain_q - GW'(atk) : '0;
    end else if (agc_on) begin
      gain_d = (sum > {1'b0, GAIN_MAX}) ? GAIN_MAX : sum[GW-1:0];
    end
  end

  // Gain pointer, update strobe and latched flags move only at the period end.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gain_q <= GAIN_INIT;
      gain_update_o <= 1'b0;
      flags_q <= 4'h0;
    end else begin
      gain_update_o <= upd;
      if (upd) begin
        gain_q <= gain_d;
        flags_q <= {hb_lo, hb_hi, apd_lo, apd_hi};
      end
    end
  end
  assign gain_index_o = gain_q;

  // Time since the last gain move, saturating; it paces fast recovery.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rec_tmr_q <= 30'h00000000;
    end else if (upd && gain_d != gain_q) begin
      rec_tmr_q <= 30'h00000000;
    end else if (rec_tmr_q != 30'h3FFFFFFF) begin
      rec_tmr_q <= rec_tmr_q + 30'h00000001;
    end
  end

  // Sticky status, write one to clear; a new event beats a clear in the same cycle.
  always_comb begin
    irq_set = upd ? {gain_d > gain_q, hb_hi || hb_lo, apd_lo, apd_hi} : 4'h0;
    irq_clr = (wr_go && aw_addr_q == `AGC_IRQ_STAT_OFS && w_strb_q[0]) ? w_data_q[3:0] : 4'h0;
  end
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat_q <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq_o <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_attack_cause;
    upd && agc_on && apd_hi && !hb_hi && gain_q >= GW'(step_q[`STEP_ATK_F]);
  endsequence
  sequence s_quiet_peak;
    upd && ctrl_q[`CTRL_PEAK] && !ctrl_q[`CTRL_POWER] && !ctrl_q[`CTRL_FAST] && !over;
  endsequence

  AST_ANALOG_ATTACK: assert property (s_attack_cause |=>
    gain_index_o == $past(gain_q) - GW'($past(step_q[`STEP_ATK_F])))
    else $error("analog attack step not applied");
  AST_PEAK_RISE: assert property (s_quiet_peak ##0 !apd_lo ##0 ({1'b0, gain_q} +
    (GW+1)'(step_q[`STEP_REC_F]) <= {1'b0, GAIN_MAX}) |=>
    gain_q == $past(gain_q) + GW'($past(step_q[`STEP_REC_F])))
    else $error("analog recovery step not applied");
  AST_NO_RISE_LOW: assert property (s_quiet_peak ##0 apd_lo |=>
    gain_q == $past(gain_q))
    else $error("gain rose during low overload");
  AST_BLOCK_RISE: assert property (upd && ctrl_q[`CTRL_POWER] && ctrl_q[`CTRL_BLOCK] &&
    !ctrl_q[`CTRL_PEAK] && apd_lo |=> gain_q <= $past(gain_q))
    else $error("gain rose while low overload blocks it");
  AST_HB_ATTACK: assert property (upd && agc_on && hb_hi && !apd_hi &&
    gain_q >= GW'(step_q[`STEP_HBATK_F]) |=>
    gain_q == $past(gain_q) - GW'($past(step_q[`STEP_HBATK_F])))
    else $error("half-band attack step not applied");
  AST_TC_HIGH: assert property ($stable(rec_q) [*3] |-> tc_high_q ==
    (30'(rec_q[`REC_HIGH_F]) + 30'h1) * (30'(rec_q[`REC_MID_F]) + 30'h1) * 30'(rec_q[`REC_LOW_F]))
    else $error("high recovery constant wrong");
  AST_HOLD_OFF: assert property (upd && !agc_on |=> $stable(gain_q))
    else $error("gain moved with gain control off");
  AST_IRQ: assert property (|(irq_stat_q & irq_mask_q) && irq_clr == 4'h0 |=> irq_o)
    else $error("interrupt missing for unmasked status");
endmodule

// [dv/agc_front_end_model.sv]
`timescale 1ns/1ns
// Far-side stand-in: analog peak detector and half-band filter output.
module agc_front_end_model (
  // Clock.
  input wire logic clk_sys_i,
  // Sample strobes.
  output logic apd_valid_o,
  output logic [5:0] apd_level_o,
  output logic hb_valid_o,
  output logic [13:0] hb_sample_o
);
  // Idle at time zero.
  initial begin
    apd_valid_o = 1'b0;
    apd_level_o = 6'h00;
    hb_valid_o = 1'b0;
    hb_sample_o = 14'h0000;
  end
  // Back-to-back peaks; the level is inverted afterwards so stale data is never trusted.
  task automatic apd(input logic [5:0] lvl, input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      apd_valid_o <= 1'b1;
      apd_level_o <= lvl;
    end
    @(posedge clk_sys_i);
    apd_valid_o <= 1'b0;
    apd_level_o <= ~lvl;
  endtask
  // Four back-to-back half-band samples, first one in the top slice.
  task automatic hb(input logic [55:0] s);
    for (int i = 3; i >= 0; i--) begin
      @(posedge clk_sys_i);
      hb_valid_o <= 1'b1;
      hb_sample_o <= s[i*14 +: 14];
    end
    @(posedge clk_sys_i);
    hb_valid_o <= 1'b0;
    hb_sample_o <= ~s[13:0];
  endtask
endmodule

// [dv/tb_agc_peak_overload_detect.sv]
`timescale 1ns/1ns
module tb_agc_peak_overload_detect import agc_pkg::*;;
  logic clk = 1'b0, reset_n = 1'b0, pwr_req = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, gain;
  logic [31:0] wdata = 32'h0000_0000, rdata, g;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, apd_valid, hb_valid, gain_update, irq;
  logic [1:0] bresp, rresp;
  logic [5:0] apd_level;
  logic [13:0] hb_sample;
  int failures = 0, checked = 0;
  // Clock of 40 ns.
  always #20 clk = ~clk;
  agc_peak_overload_detect dut (.clk_sys_i(clk), .reset_n_i(reset_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .apd_valid_i(apd_valid),
    .apd_level_i(apd_level), .hb_valid_i(hb_valid), .hb_sample_i(hb_sample),
    .pwr_rise_req_i(pwr_req), .gain_index_o(gain), .gain_update_o(gain_update),
    .irq_o(irq));
  agc_front_end_model fe (.clk_sys_i(clk), .apd_valid_o(apd_valid),
    .apd_level_o(apd_level), .hb_valid_o(hb_valid), .hb_sample_o(hb_sample));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write; address and data are released independently as each is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp("bresp", 32'(r), 32'(bresp));
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    cmp(n, e, rdata);
    cmp("rresp", 32'(r), 32'(rresp));
  endtask
  // Align to a gain update; only the starting point is taken from the design.
  task automatic sync();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (gain_update !== 1'b1 && k < 200);
    cmp("gain_update", 32'h1, 32'(gain_update));
    g = 32'(gain);
  endtask
  // One 16-cycle period of stimulus, then the gain step it must produce.
  task automatic per(input logic [5:0] l, input int n, input int h, input int dlt);
    fork
      fe.apd(l, n);
      if (h == 1) fe.hb({4{14'h00C8}});
      if (h == 2) fe.hb({14'h00C8, {3{14'h000A}}});
      if (h == 3) fe.hb({4{14'h3FFF}});
      repeat (16) @(posedge clk);
    join
    g = g + 32'(dlt);
    cmp("gain", g, 32'(gain));
  endtask
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // A hang is cut short well beyond the expected run length.
  initial begin
    #800000;
    failures++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    cmp("gain", 32'hFF, 32'(gain));
    cmp("irq", 32'h0, 32'(irq));
    rd("ctrl", 8'h00, 32'h0000_0011, RESP_OKAY);
    rd("apd", 8'h04, 32'h0306_0C15, RESP_OKAY);
    rd("step", 8'h08, 32'h0002_0002, RESP_OKAY);
    rd("hb", 8'h0C, 32'h0003_0611, RESP_OKAY);
    rd("hblvl", 8'h10, 32'h2710_32F4, RESP_OKAY);
    rd("rec", 8'h14, 32'h0032_0204, RESP_OKAY);
    rd("tc_mid", 8'h28, 32'h0000_0096, RESP_OKAY);
    rd("tc_high", 8'h2C, 32'h0000_02EE, RESP_OKAY);
    rd("unmapped", 8'h30, 32'h0, RESP_SLVERR);
    wr(8'h30, 32'h1, RESP_SLVERR);
    wr(8'h18, 32'h0010_1CA7, RESP_OKAY);
    wr(8'h08, 32'h0003_0102, RESP_OKAY);
    wr(8'h04, 32'h0302_0C15, RESP_OKAY);
    wr(8'h0C, 32'h00FF_0012, RESP_OKAY);
    wr(8'h10, 32'h0032_0064, RESP_OKAY);
    wr(8'h00, 32'h0000_0001, RESP_OKAY);
    wr(8'h24, 32'h0000_0001, RESP_OKAY);
    // Long flood pulls the gain well below the top so rises never clamp later.
    fe.apd(6'd30, 200);
    cmp("irq", 32'h1, 32'(irq));
    // Let the last flooded period close first, else its event would beat the clear.
    repeat (20) @(posedge clk);
    wr(8'h20, 32'h0000_000F, RESP_OKAY);
    repeat (3) @(posedge clk);
    cmp("irq", 32'h0, 32'(irq));
    sync();
    per(6'd0, 0, 0, 1);
    per(6'd30, 1, 0, 1);
    per(6'd30, 1, 0, 1);
    per(6'd30, 2, 0, -2);
    per(6'd15, 3, 0, 0);
    per(6'd15, 2, 0, 1);
    wr(8'h00, 32'h0000_0011, RESP_OKAY);
    sync();
    per(6'd0, 0, 1, -3);
    per(6'd0, 0, 2, 1);
    wr(8'h00, 32'h0000_0001, RESP_OKAY);
    sync();
    per(6'd0, 0, 1, 1);
    // Fast recovery with short constants: a loud half-band period holds the gain.
    wr(8'h14, 32'h0002_0001, RESP_OKAY);
    wr(8'h00, 32'h0000_0005, RESP_OKAY);
    rd("tc_mid", 8'h28, 32'h0000_0002, RESP_OKAY);
    rd("tc_high", 8'h2C, 32'h0000_0004, RESP_OKAY);
    sync();
    per(6'd0, 0, 0, 1);
    per(6'd0, 0, 3, 0);
    wr(8'h08, 32'h0103_0102, RESP_OKAY);
    wr(8'h00, 32'h0000_000A, RESP_OKAY);
    pwr_req <= 1'b1;
    sync();
    per(6'd15, 3, 0, 0);
    per(6'd0, 0, 0, 1);
    per(6'd30, 2, 0, -2);
    final_report();
  end
endmodule
